// ---- aeia_defs.svh ----
// offsets, field positions, reset values and address map of the exception unit
`ifndef AEIA_DEFS_SVH
`define AEIA_DEFS_SVH

// ==================================================
// register byte offsets
`define AEIA_OFS_CTRL       8'h00
`define AEIA_OFS_VBASE      8'h04
`define AEIA_OFS_STATUS     8'h08
`define AEIA_OFS_ERR_ADDR   8'h0c
`define AEIA_OFS_PRIO0      8'h10
`define AEIA_NUM_PRIO_REGS  6

// ==================================================
// field positions
`define AEIA_CTRL_SINGLE    0
`define AEIA_STAT_ERR_CPU   0
`define AEIA_STAT_ERR_DMA   1
`define AEIA_STAT_NMI_PEND  2
`define AEIA_STAT_STATE_LSB 4
`define AEIA_STAT_VEC_LSB   8
`define AEIA_SR_MASK_LSB    4

// ==================================================
// reset values
`define AEIA_RST_CTRL       32'h0000_0000
`define AEIA_RST_VBASE      32'h0000_0000
`define AEIA_RST_PRIO       4'h0

// ==================================================
// vector numbers and levels
`define AEIA_VEC_CPU_ERR    8'h09
`define AEIA_VEC_DMA_ERR    8'h0a
`define AEIA_VEC_NMI        8'h0b
`define AEIA_VEC_UBRK       8'h0c
`define AEIA_VEC_REQ0       8'h40
`define AEIA_LVL_NMI        5'h10
`define AEIA_LVL_UBRK       5'h0f
`define AEIA_MASK_NMI       4'hf

// ==================================================
// address map
`define AEIA_PERIPH_BASE    32'hffff_8000
`define AEIA_PERIPH_MASK    32'hffff_8000
`define AEIA_PERIPH8_BASE   32'hffff_8000
`define AEIA_PERIPH8_MASK   32'hffff_fc00
`define AEIA_EXT_LO         32'h0040_0000
`define AEIA_EXT_HI         32'hfeff_ffff

`endif

// ---- aeia_pkg.sv ----
// types shared by the exception unit
package aeia_pkg;

	// ==================================================
	// sequencer states
	typedef enum logic [2:0]
	{
		ST_IDLE      = 3'b000,
		ST_PUSH_SR   = 3'b001,
		ST_PUSH_PC   = 3'b010,
		ST_FETCH_VEC = 3'b011,
		ST_JUMP      = 3'b100
	} aeia_state_t;

	// ==================================================
	// access size and bus master
	typedef enum logic [1:0]
	{
		SZ_BYTE = 2'b00,
		SZ_WORD = 2'b01,
		SZ_LONG = 2'b10
	} aeia_size_t;

	typedef enum logic [1:0]
	{
		MST_CPU = 2'b00,
		MST_DMA = 2'b01,
		MST_DTE = 2'b10
	} aeia_master_t;

endpackage

// ---- aeia_core.sv ----
// address error checker, interrupt arbiter and exception push-and-vector sequencer
//
// Overview of operation
// - odd instruction fetch raises address error
// - fetch from peripheral space raises error
// - single-chip mode: external fetch raises error
// - word data access at odd address errors
// - misaligned longword data access raises error
// - longword to 8-bit peripheral region errors
// - single-chip mode: external data access errors
// - terminate cycle; process after instruction ends
// - address error: push status, pc, vector
// - four request classes incl. peripheral sources
// - every source owns a distinct vector
// - highest pending priority level wins
// - non-maskable level 16, always accepted
// - user break fixed at level 15
// - other sources programmable 0 to 15
// - maskable accepted only above mask field
// - push status word then program counter
// - mask loaded with level, 15 for nmi
// - fetch handler from vector, jump there
// - vector entry is base plus four times number
//
// Our own choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`include "aeia_defs.svh"

module aeia_core
#(
	parameter int NUM_EXT    = 8,
	parameter int NUM_PERIPH = 36
)
(
	// clock and reset
	input  wire logic                  CLK_SYS_IN,
	input  wire logic                  RESET_N_IN,
	// apb slave
	input  wire logic                  PSEL_IN,
	input  wire logic                  PENABLE_IN,
	input  wire logic                  PWRITE_IN,
	input  wire logic [7:0]            PADDR_IN,
	input  wire logic [31:0]           PWDATA_IN,
	output logic                       PREADY_OUT,
	output logic [31:0]                PRDATA_OUT,
	output logic                       PSLVERR_OUT,
	// bus access under check
	input  wire logic                  ACC_VALID_IN,
	input  wire logic                  ACC_FETCH_IN,
	input  wire aeia_pkg::aeia_size_t  ACC_SIZE_IN,
	input  wire aeia_pkg::aeia_master_t ACC_MASTER_IN,
	input  wire logic [31:0]           ACC_ADDR_IN,
	output logic                       ACC_ABORT_OUT,
	// interrupt sources
	input  wire logic                  NMI_N_IN,
	input  wire logic                  UBRK_REQ_IN,
	input  wire logic [NUM_EXT-1:0]    EXT_REQ_N_IN,
	input  wire logic [NUM_PERIPH-1:0] PERIPH_REQ_IN,
	// core sequencer side
	input  wire logic                  INSN_END_IN,
	input  wire logic [31:0]           STATUS_WORD_IN,
	input  wire logic [31:0]           NEXT_PC_IN,
	input  wire logic [31:0]           STACK_PTR_IN,
	output logic                       MEM_REQ_OUT,
	output logic                       MEM_WE_OUT,
	output logic [31:0]                MEM_ADDR_OUT,
	output logic [31:0]                MEM_WDATA_OUT,
	input  wire logic                  MEM_ACK_IN,
	input  wire logic [31:0]           MEM_RDATA_IN,
	output logic                       JUMP_OUT,
	output logic [31:0]                JUMP_PC_OUT,
	output logic [31:0]                NEW_STATUS_OUT,
	output logic [31:0]                NEW_SP_OUT
);
	import aeia_pkg::*;

	localparam int NSRC = NUM_EXT + NUM_PERIPH;

	// ==================================================
	// state
	typedef struct packed
	{
		logic [2:0]            nmi_sync;
		logic                  nmi_f;
		logic                  nmi_pend;
		logic [NUM_EXT-1:0]    ext_s1;
		logic [NUM_EXT-1:0]    ext_s2;
		logic [NUM_EXT-1:0]    ext_s3;
		logic [NUM_EXT-1:0]    ext_f;
		logic                  err_cpu;
		logic                  err_dma;
		logic [31:0]           err_addr;
		logic                  abort;
		logic                  single;
		logic [31:0]           vbase;
		logic [NSRC-1:0][3:0]  prio;
		aeia_state_t           state;
		logic [7:0]            vec;
		logic [3:0]            new_mask;
		logic [31:0]           sr;
		logic [31:0]           pc;
		logic [31:0]           sp;
		logic                  pready;
		logic [31:0]           prdata;
		logic                  pslverr;
		logic                  mem_req;
		logic                  mem_we;
		logic [31:0]           mem_addr;
		logic [31:0]           mem_wdata;
		logic                  jump;
		logic [31:0]           jump_pc;
		logic [31:0]           new_sr;
		logic [31:0]           new_sp;
	} aeia_core_state_t;

	aeia_core_state_t s_q;
	aeia_core_state_t s_d;

	// ==================================================
	// combinational helpers
	logic                 in_periph;
	logic                 in_periph8;
	logic                 in_ext;
	logic                 acc_err;
	logic [NSRC-1:0]      req_vec;
	logic [3:0]           cur_mask;
	logic                 cand;
	logic [4:0]           cand_lvl;
	logic [7:0]           cand_vec;
	logic                 apb_setup;
	logic                 apb_wr;
	logic [7:0]           prio_ofs;

	always_comb
	begin
		in_periph  = (ACC_ADDR_IN & `AEIA_PERIPH_MASK) == `AEIA_PERIPH_BASE;
		in_periph8 = (ACC_ADDR_IN & `AEIA_PERIPH8_MASK) == `AEIA_PERIPH8_BASE;
		in_ext     = (ACC_ADDR_IN >= `AEIA_EXT_LO) && (ACC_ADDR_IN <= `AEIA_EXT_HI);
		if (ACC_FETCH_IN)
		begin
			acc_err = ACC_ADDR_IN[0]
				| in_periph
				| (s_q.single & in_ext);
		end
		else
		begin
			acc_err = ((ACC_SIZE_IN == SZ_WORD) & ACC_ADDR_IN[0])
				| ((ACC_SIZE_IN == SZ_LONG) & (ACC_ADDR_IN[1:0] != 2'b00))
				| ((ACC_SIZE_IN == SZ_LONG) & in_periph & in_periph8)
				| (s_q.single & in_ext);
		end
	end

	// arbitration: maskable requests are live levels, so a masked one is simply looked at again
	always_comb
	begin
		req_vec  = {PERIPH_REQ_IN, s_q.ext_f};
		cur_mask = STATUS_WORD_IN[`AEIA_SR_MASK_LSB +: 4];
		cand     = 1'b0;
		cand_lvl = 5'h00;
		cand_vec = 8'h00;
		if (s_q.nmi_pend)
		begin
			cand     = 1'b1;
			cand_lvl = `AEIA_LVL_NMI;
			cand_vec = `AEIA_VEC_NMI;
		end
		else if (UBRK_REQ_IN && (`AEIA_LVL_UBRK > {1'b0, cur_mask}))
		begin
			cand     = 1'b1;
			cand_lvl = `AEIA_LVL_UBRK;
			cand_vec = `AEIA_VEC_UBRK;
		end
		else
		begin
			for (int i = 0; i < NSRC; i++)
			begin
				// strict compare keeps lowest index on a tie
				if (req_vec[i] && (s_q.prio[i] > cur_mask)
					&& ({1'b0, s_q.prio[i]} > cand_lvl || !cand))
				begin
					cand     = 1'b1;
					cand_lvl = {1'b0, s_q.prio[i]};
					cand_vec = `AEIA_VEC_REQ0 + 8'(i);
				end
			end
		end
	end

	always_comb
	begin
		apb_setup = PSEL_IN & ~PENABLE_IN;
		apb_wr    = PSEL_IN & PENABLE_IN & s_q.pready & PWRITE_IN;
		prio_ofs  = PADDR_IN - `AEIA_OFS_PRIO0;
	end

	// ==================================================
	// next state
	always_comb
	begin
		s_d = s_q;

		// pin synchronisers, a change counts once stages two and three agree
		s_d.nmi_sync = {s_q.nmi_sync[1:0], ~NMI_N_IN};
		if (s_q.nmi_sync[1] == s_q.nmi_sync[2])
			s_d.nmi_f = s_q.nmi_sync[1];
		s_d.ext_s1 = ~EXT_REQ_N_IN;
		s_d.ext_s2 = s_q.ext_s1;
		s_d.ext_s3 = s_q.ext_s2;
		for (int i = 0; i < NUM_EXT; i++)
		begin
			if (s_q.ext_s2[i] == s_q.ext_s3[i])
				s_d.ext_f[i] = s_q.ext_s2[i];
		end

		// access check
		s_d.abort = ACC_VALID_IN & acc_err;

		// ----- apb slave
		s_d.pready  = apb_setup;
		s_d.pslverr = 1'b0;
		s_d.prdata  = 32'h0000_0000;
		if (apb_setup)
		begin
			if (PADDR_IN == `AEIA_OFS_CTRL)
				s_d.prdata[`AEIA_CTRL_SINGLE] = s_q.single;
			else if (PADDR_IN == `AEIA_OFS_VBASE)
				s_d.prdata = s_q.vbase;
			else if (PADDR_IN == `AEIA_OFS_STATUS)
			begin
				s_d.prdata[`AEIA_STAT_ERR_CPU]      = s_q.err_cpu;
				s_d.prdata[`AEIA_STAT_ERR_DMA]      = s_q.err_dma;
				s_d.prdata[`AEIA_STAT_NMI_PEND]     = s_q.nmi_pend;
				s_d.prdata[`AEIA_STAT_STATE_LSB +: 3] = s_q.state;
				s_d.prdata[`AEIA_STAT_VEC_LSB +: 8]   = s_q.vec;
			end
			else if (PADDR_IN == `AEIA_OFS_ERR_ADDR)
				s_d.prdata = s_q.err_addr;
			else if (PADDR_IN >= `AEIA_OFS_PRIO0 && PADDR_IN[1:0] == 2'b00
				&& prio_ofs < 8'(4 * `AEIA_NUM_PRIO_REGS))
			begin
				// register k at offset 10h plus 4k holds sources 8k to 8k+7
				for (int j = 0; j < 8; j++)
				begin
					if (int'(prio_ofs) * 2 + j < NSRC)
						s_d.prdata[4*j +: 4] = s_q.prio[int'(prio_ofs) * 2 + j];
				end
			end
			else
				s_d.pslverr = 1'b1;
		end
		if (apb_wr)
		begin
			if (PADDR_IN == `AEIA_OFS_CTRL)
				s_d.single = PWDATA_IN[`AEIA_CTRL_SINGLE];
			else if (PADDR_IN == `AEIA_OFS_VBASE)
				s_d.vbase = PWDATA_IN;
			else if (PADDR_IN >= `AEIA_OFS_PRIO0 && PADDR_IN[1:0] == 2'b00
				&& prio_ofs < 8'(4 * `AEIA_NUM_PRIO_REGS))
			begin
				for (int j = 0; j < 8; j++)
				begin
					// a 4-bit field cannot hold level 16
					if (int'(prio_ofs) * 2 + j < NSRC)
						s_d.prio[int'(prio_ofs) * 2 + j] = PWDATA_IN[4*j +: 4];
				end
			end
		end

		// ----- sequencer; clears first so that a new set in the same cycle wins
		s_d.jump = 1'b0;
		case (s_q.state)
			ST_IDLE:
			begin
				if (INSN_END_IN && (s_q.err_cpu || s_q.err_dma || cand))
				begin
					s_d.sr    = STATUS_WORD_IN;
					s_d.pc    = NEXT_PC_IN;
					s_d.sp    = STACK_PTR_IN;
					s_d.state = ST_PUSH_SR;
					if (s_q.err_cpu)
					begin
						s_d.err_cpu  = 1'b0;
						s_d.vec      = `AEIA_VEC_CPU_ERR;
						s_d.new_mask = STATUS_WORD_IN[`AEIA_SR_MASK_LSB +: 4];
					end
					else if (s_q.err_dma)
					begin
						s_d.err_dma  = 1'b0;
						s_d.vec      = `AEIA_VEC_DMA_ERR;
						s_d.new_mask = STATUS_WORD_IN[`AEIA_SR_MASK_LSB +: 4];
					end
					else
					begin
						s_d.vec = cand_vec;
						if (s_q.nmi_pend)
						begin
							s_d.nmi_pend = 1'b0;
							s_d.new_mask = `AEIA_MASK_NMI;
						end
						else
						begin
							s_d.new_mask = cand_lvl[3:0];
						end
					end
					s_d.mem_req   = 1'b1;
					s_d.mem_we    = 1'b1;
					s_d.mem_addr  = STACK_PTR_IN - 32'h0000_0004;
					s_d.mem_wdata = STATUS_WORD_IN;
				end
			end
			ST_PUSH_SR:
			begin
				if (MEM_ACK_IN)
				begin
					s_d.state     = ST_PUSH_PC;
					s_d.mem_addr  = s_q.sp - 32'h0000_0008;
					s_d.mem_wdata = s_q.pc;
				end
			end
			ST_PUSH_PC:
			begin
				if (MEM_ACK_IN)
				begin
					s_d.state     = ST_FETCH_VEC;
					s_d.mem_we    = 1'b0;
					s_d.mem_wdata = 32'h0000_0000;
					s_d.mem_addr  = s_q.vbase + {22'h000000, s_q.vec, 2'b00};
				end
			end
			ST_FETCH_VEC:
			begin
				if (MEM_ACK_IN)
				begin
					s_d.state   = ST_JUMP;
					s_d.mem_req = 1'b0;
					s_d.jump    = 1'b1;
					s_d.jump_pc = MEM_RDATA_IN;
					s_d.new_sp  = s_q.sp - 32'h0000_0008;
					s_d.new_sr  = s_q.sr;
					s_d.new_sr[`AEIA_SR_MASK_LSB +: 4] = s_q.new_mask;
				end
			end
			ST_JUMP:
				s_d.state = ST_IDLE;
			default:
			begin
				s_d.state   = ST_IDLE;
				s_d.mem_req = 1'b0;
			end
		endcase

		// event sets last: they win over any clear above
		if (s_d.nmi_f && !s_q.nmi_f)
			s_d.nmi_pend = 1'b1;
		if (ACC_VALID_IN && acc_err)
		begin
			s_d.err_addr = ACC_ADDR_IN;
			s_d.err_cpu  = s_d.err_cpu | (ACC_MASTER_IN == MST_CPU);
			s_d.err_dma  = s_d.err_dma | (ACC_MASTER_IN != MST_CPU);
		end
	end

	// ==================================================
	// registers
	always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN)
	begin
		if (!RESET_N_IN)
		begin
			s_q          <= '0;
			s_q.single   <= 1'(`AEIA_RST_CTRL >> `AEIA_CTRL_SINGLE);
			s_q.vbase    <= `AEIA_RST_VBASE;
			s_q.prio     <= {NSRC{`AEIA_RST_PRIO}};
			s_q.state    <= ST_IDLE;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	// ==================================================
	// outputs
	assign PREADY_OUT     = s_q.pready;
	assign PRDATA_OUT     = s_q.prdata;
	assign PSLVERR_OUT    = s_q.pslverr;
	assign ACC_ABORT_OUT  = s_q.abort;
	assign MEM_REQ_OUT    = s_q.mem_req;
	assign MEM_WE_OUT     = s_q.mem_we;
	assign MEM_ADDR_OUT   = s_q.mem_addr;
	assign MEM_WDATA_OUT  = s_q.mem_wdata;
	assign JUMP_OUT       = s_q.jump;
	assign JUMP_PC_OUT    = s_q.jump_pc;
	assign NEW_STATUS_OUT = s_q.new_sr;
	assign NEW_SP_OUT     = s_q.new_sp;

endmodule

// ---- aeia_core_asserts.sv ----
// port checker for the exception unit
`timescale 1ns/1ps
`include "aeia_defs.svh"

module aeia_core_asserts
#(
	parameter int NUM_EXT    = 8,
	parameter int NUM_PERIPH = 36
)
(
	// clock, reset, apb
	input wire logic                 CLK_SYS_IN,
	input wire logic                 RESET_N_IN,
	input wire logic                 PREADY_OUT,
	input wire logic                 PSLVERR_OUT,
	// access check
	input wire logic                 ACC_VALID_IN,
	input wire logic                 ACC_FETCH_IN,
	input wire aeia_pkg::aeia_size_t ACC_SIZE_IN,
	input wire logic [31:0]          ACC_ADDR_IN,
	input wire logic                 ACC_ABORT_OUT,
	// sequencer
	input wire logic [31:0]          STATUS_WORD_IN,
	input wire logic [31:0]          NEXT_PC_IN,
	input wire logic [31:0]          STACK_PTR_IN,
	input wire logic                 MEM_REQ_OUT,
	input wire logic                 MEM_WE_OUT,
	input wire logic [31:0]          MEM_ADDR_OUT,
	input wire logic [31:0]          MEM_WDATA_OUT,
	input wire logic                 MEM_ACK_IN,
	input wire logic [31:0]          MEM_RDATA_IN,
	input wire logic                 JUMP_OUT,
	input wire logic [31:0]          JUMP_PC_OUT,
	input wire logic [31:0]          NEW_SP_OUT
);
	import aeia_pkg::*;

	// ==========
	// access checks
	default clocking cb @(posedge CLK_SYS_IN); endclocking
	default disable iff (!RESET_N_IN);
	wire fet = ACC_VALID_IN && ACC_FETCH_IN;
	wire dat = ACC_VALID_IN && !ACC_FETCH_IN;
	wire lng = dat && ACC_SIZE_IN == SZ_LONG;

	a_fetch_odd: assert property (fet && ACC_ADDR_IN[0] |=> ACC_ABORT_OUT)
		else $error("odd fetch not aborted");
	a_fetch_periph: assert property (fet && (ACC_ADDR_IN & `AEIA_PERIPH_MASK)
		== `AEIA_PERIPH_BASE |=> ACC_ABORT_OUT)
		else $error("peripheral fetch not aborted");
	a_word_odd: assert property (dat && ACC_SIZE_IN == SZ_WORD && ACC_ADDR_IN[0]
		|=> ACC_ABORT_OUT)
		else $error("odd word not aborted");
	a_long_align: assert property (lng && ACC_ADDR_IN[1:0] != 2'h0 |=> ACC_ABORT_OUT)
		else $error("misaligned long not aborted");
	a_long_narrow: assert property (lng && (ACC_ADDR_IN & `AEIA_PERIPH8_MASK)
		== `AEIA_PERIPH8_BASE |=> ACC_ABORT_OUT)
		else $error("long to narrow region not aborted");
	a_abort_cause: assert property (ACC_ABORT_OUT |-> $past(ACC_VALID_IN))
		else $error("abort without access");

	// ==========
	// sequencer
	a_push_status: assert property ($rose(MEM_REQ_OUT) |-> MEM_WE_OUT
		&& MEM_WDATA_OUT == $past(STATUS_WORD_IN)
		&& MEM_ADDR_OUT == $past(STACK_PTR_IN) - 32'h4)
		else $error("first push wrong");
	a_push_pc: assert property (MEM_REQ_OUT && MEM_WE_OUT && MEM_ACK_IN
		&& MEM_ADDR_OUT == STACK_PTR_IN - 32'h4 |=> MEM_REQ_OUT && MEM_WE_OUT
		&& MEM_ADDR_OUT == STACK_PTR_IN - 32'h8 && MEM_WDATA_OUT == NEXT_PC_IN)
		else $error("second push wrong");
	a_req_hold: assert property (MEM_REQ_OUT && !MEM_ACK_IN |=> MEM_REQ_OUT
		&& $stable(MEM_ADDR_OUT) && $stable(MEM_WE_OUT))
		else $error("request dropped before ack");
	a_vec_align: assert property (MEM_REQ_OUT && !MEM_WE_OUT
		|-> MEM_ADDR_OUT[1:0] == 2'h0)
		else $error("vector read misaligned");
	a_jump_pc: assert property (JUMP_OUT |-> $past(MEM_ACK_IN) && !$past(MEM_WE_OUT)
		&& JUMP_PC_OUT == $past(MEM_RDATA_IN))
		else $error("jump target not fetched vector");
	a_new_sp: assert property (JUMP_OUT |-> NEW_SP_OUT == STACK_PTR_IN - 32'h8)
		else $error("stack pointer wrong");

	c_jump: cover property (JUMP_OUT);
	c_abort: cover property (ACC_ABORT_OUT);
	c_slverr: cover property (PREADY_OUT && PSLVERR_OUT);
endmodule

bind aeia_core aeia_core_asserts #(.NUM_EXT(NUM_EXT), .NUM_PERIPH(NUM_PERIPH)) aeia_core_asserts_inst (.*);

// ---- aeia_mem_model.sv ----
// core memory side: acks sequencer requests after a random delay
`timescale 1ns/1ps

module aeia_mem_model
#(
	parameter logic [31:0] KEY = 32'h5a00_0000
)
(
	// sequencer memory port
	input  wire logic        CLK_SYS_IN,
	input  wire logic        MEM_REQ_OUT,
	input  wire logic [31:0] MEM_ADDR_OUT,
	output logic             MEM_ACK_IN,
	output logic [31:0]      MEM_RDATA_IN
);
	logic [1:0] dly_q = 2'h0;

	initial
	begin
		MEM_ACK_IN = 1'b0;
		MEM_RDATA_IN = 32'h0;
	end

	// ==========
	// read data toggles outside an ack
	always @(posedge CLK_SYS_IN)
	begin
		MEM_ACK_IN <= 1'b0;
		MEM_RDATA_IN <= ~MEM_RDATA_IN;
		if (MEM_REQ_OUT && !MEM_ACK_IN)
			if (dly_q != 2'h0)
				dly_q <= dly_q - 2'h1;
			else
			begin
				MEM_ACK_IN <= 1'b1;
				MEM_RDATA_IN <= MEM_ADDR_OUT ^ KEY;
				dly_q <= 2'($urandom_range(2, 0));
			end
	end
endmodule

// ---- aeia_core_bench.sv ----
// self-checking bench of the exception unit
`timescale 1ns/1ps

module aeia_core_bench;
	import aeia_pkg::*;

	localparam logic [31:0] KEY = 32'h5a00_0000;
	logic CLK_SYS_IN = 0, RESET_N_IN = 0, PSEL_IN = 0, PENABLE_IN = 0, PWRITE_IN = 0;
	logic [7:0] PADDR_IN = 0;
	logic [31:0] PWDATA_IN = 0, ACC_ADDR_IN = 0, PRDATA_OUT, MEM_ADDR_OUT, MEM_WDATA_OUT;
	logic PREADY_OUT, PSLVERR_OUT, ACC_ABORT_OUT, MEM_REQ_OUT, MEM_WE_OUT, MEM_ACK_IN;
	logic ACC_VALID_IN = 0, ACC_FETCH_IN = 0, NMI_N_IN = 1, UBRK_REQ_IN = 0, INSN_END_IN = 0;
	aeia_size_t ACC_SIZE_IN = SZ_BYTE;
	aeia_master_t ACC_MASTER_IN = MST_CPU;
	logic [7:0] EXT_REQ_N_IN = 8'hff;
	logic [35:0] PERIPH_REQ_IN = 0;
	logic [31:0] STATUS_WORD_IN = 32'h0000_0231, NEXT_PC_IN = 32'h0000_2468;
	logic [31:0] STACK_PTR_IN = 32'h0000_8000, MEM_RDATA_IN, JUMP_PC_OUT;
	logic [31:0] NEW_STATUS_OUT, NEW_SP_OUT, vb = 0, sw = 32'h0000_0231;
	logic JUMP_OUT, v_q = 0;
	logic [3:0] lv;
	logic [63:0] qr[$], qj[$];
	logic qa[$];
	int n_fail = 0, compares = 0;

	aeia_core aeia_core_inst (.*);
	aeia_mem_model #(.KEY(KEY)) aeia_mem_model_inst (.*);

	always #20 CLK_SYS_IN = ~CLK_SYS_IN;

	// ==========
	// tasks
	task test_done;
		if (n_fail == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task chk(input logic [63:0] e, input logic [63:0] g);
		compares++;
		if (g !== e)
		begin
			n_fail++;
			$display("Error at %0t: expected %h got %h", $time, e, g);
		end
	endtask

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
		@(posedge CLK_SYS_IN);
		PSEL_IN <= 1;
		PWRITE_IN <= w;
		PADDR_IN <= a;
		PWDATA_IN <= d;
		if (!w)
			qr.push_back(e);
		@(posedge CLK_SYS_IN);
		PENABLE_IN <= 1;
		do
			@(posedge CLK_SYS_IN);
		while (PREADY_OUT !== 1'b1);
		PSEL_IN <= 0;
		PENABLE_IN <= 0;
	endtask

	task rd(input logic [7:0] a, input logic [31:0] e);
		apb(0, a, 0, {1'b0, e});
	endtask

	task acc(input logic f, aeia_size_t s, aeia_master_t m, logic [31:0] a, logic e);
		@(posedge CLK_SYS_IN);
		ACC_VALID_IN <= 1;
		ACC_FETCH_IN <= f;
		ACC_SIZE_IN <= s;
		ACC_MASTER_IN <= m;
		ACC_ADDR_IN <= a;
		qa.push_back(e);
	endtask

	task sm(input logic [3:0] m);
		@(posedge CLK_SYS_IN);
		sw[7:4] = m;
		STATUS_WORD_IN <= sw;
		repeat (6) @(posedge CLK_SYS_IN);
	endtask

	task sq(input logic go, input logic [7:0] v, input logic [3:0] m);
		if (go)
			qj.push_back({(vb + 32'(v) * 4) ^ KEY, sw & ~32'hf0 | 32'(m) << 4});
		@(posedge CLK_SYS_IN);
		INSN_END_IN <= 1;
		@(posedge CLK_SYS_IN);
		INSN_END_IN <= 0;
		for (int n = 0; n < 30 && JUMP_OUT !== 1'b1; n++)
			@(posedge CLK_SYS_IN);
		repeat (2) @(posedge CLK_SYS_IN);
	endtask

	// ==========
	// result watcher
	always @(posedge CLK_SYS_IN)
	begin
		if (v_q)
			chk(qa.size() ? qa.pop_front() : 'x, ACC_ABORT_OUT);
		v_q <= ACC_VALID_IN;
		if (PREADY_OUT && !PWRITE_IN)
			chk(qr.size() ? qr.pop_front() : 'x, {PSLVERR_OUT, PRDATA_OUT});
		if (JUMP_OUT)
			chk(qj.size() ? qj.pop_front() : 'x, {JUMP_PC_OUT, NEW_STATUS_OUT});
	end

	initial
	begin
		repeat (5000) @(posedge CLK_SYS_IN);
		n_fail++;
		test_done;
	end

	// ==========
	// main sequence
	initial
	begin
		void'($urandom(31));
		repeat (3) @(posedge CLK_SYS_IN);
		RESET_N_IN <= 1;
		rd(8'h00, 0);
		rd(8'h04, 0);
		rd(8'h10, 0);
		rd(8'h24, 0);
		apb(0, 8'h40, 0, {1'b1, 32'h0});
		apb(1, 8'h04, 32'h1000, 0);
		vb = 32'h1000;
		apb(1, 8'h08, 32'hffff, 0);
		rd(8'h04, vb);
		rd(8'h08, 0);
		acc(1, SZ_WORD, MST_CPU, 32'h100, 0);
		acc(1, SZ_WORD, MST_CPU, 32'h101, 1);
		acc(1, SZ_WORD, MST_CPU, 32'hffff_8100, 1);
		acc(1, SZ_WORD, MST_CPU, 32'h0040_0000, 0);
		acc(0, SZ_WORD, MST_DMA, 32'h203, 1);
		acc(0, SZ_WORD, MST_DMA, 32'h202, 0);
		acc(0, SZ_LONG, MST_DTE, 32'h202, 1);
		acc(0, SZ_LONG, MST_DTE, 32'h204, 0);
		acc(0, SZ_LONG, MST_CPU, 32'hffff_8000, 1);
		acc(0, SZ_LONG, MST_CPU, 32'hffff_8400, 0);
		acc(0, SZ_BYTE, MST_DMA, 32'hffff_8001, 0);
		@(posedge CLK_SYS_IN);
		ACC_VALID_IN <= 0;
		apb(1, 8'h00, 32'h1, 0);
		rd(8'h00, 32'h1);
		acc(1, SZ_WORD, MST_CPU, 32'h0040_0000, 1);
		acc(0, SZ_BYTE, MST_DMA, 32'h0050_0000, 1);
		for (int i = 0; i < 8; i++)
			acc(0, SZ_LONG, aeia_master_t'(i % 3), {10'h0, 20'($urandom), 2'h0}, 0);
		@(posedge CLK_SYS_IN);
		ACC_VALID_IN <= 0;
		rd(8'h08, 32'h3);
		sq(1, 8'd9, 4'h3);
		sq(1, 8'd10, 4'h3);
		apb(1, 8'h10, 32'h5, 0);
		apb(1, 8'h14, 32'h9, 0);
		EXT_REQ_N_IN[0] <= 0;
		PERIPH_REQ_IN[0] <= 1;
		repeat (6) @(posedge CLK_SYS_IN);
		sq(1, 8'd72, 4'h9);
		PERIPH_REQ_IN <= 0;
		sm(4'h9);
		sq(0, 0, 0);
		sm(4'h5);
		sq(0, 0, 0);
		sm(4'h4);
		sq(1, 8'd64, 4'h5);
		EXT_REQ_N_IN <= 8'hff;
		lv = 4'($urandom_range(15, 1));
		apb(1, 8'h10, 32'(lv) << 12, 0);
		EXT_REQ_N_IN[3] <= 0;
		sm(lv - 4'h1);
		sq(1, 8'd67, lv);
		UBRK_REQ_IN <= 1;
		sm(4'he);
		sq(1, 8'd12, 4'hf);
		sm(4'hf);
		sq(0, 0, 0);
		UBRK_REQ_IN <= 0;
		NMI_N_IN <= 0;
		sm(4'h0);
		sq(1, 8'd11, 4'hf);
		sq(1, 8'd67, lv);
		NMI_N_IN <= 1;
		EXT_REQ_N_IN <= 8'hff;
		repeat (4) @(posedge CLK_SYS_IN);
		// every expected result must have been seen
		chk(64'h0, 64'(qa.size() + qr.size() + qj.size()));
		test_done;
	end
endmodule
